// >>> logic/ppr_fifo.v
`timescale 1ns/1ps
module ppr_fifo #(
    parameter W     = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire          clk,
    input  wire          rstn,
    input  wire          clr,
    // fill side
    input  wire          wr_valid,
    input  wire [W-1:0]  wr_data,
    output wire          wr_ready,
    // drain side
    output wire [W-1:0]  head,
    input  wire          pop,
    output wire          empty,
    output wire          full,
    output wire [AW:0]   count
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp;
    reg [AW-1:0] rp;
    reg [AW:0]   cnt;
    wire         do_wr = wr_valid && !full;
    wire         do_rd = pop && !empty;

    assign empty    = (cnt == {(AW+1){1'b0}});
    assign full     = (cnt == DEPTH[AW:0]);
    assign wr_ready = !full;
    assign head     = mem[rp];
    assign count    = cnt;

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wp] <= wr_data;
        end
    end

    // depth need not be a power of two, so pointers wrap by compare
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp  <= {AW{1'b0}};
            rp  <= {AW{1'b0}};
            cnt <= {(AW+1){1'b0}};
        end else if (clr) begin
            wp  <= {AW{1'b0}};
            rp  <= {AW{1'b0}};
            cnt <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
            end
            if (do_rd) begin
                rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt <= cnt + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule

// >>> logic/ppr_fwd.v
`timescale 1ns/1ps
`include "ppr_regs.vh"
module ppr_fwd #(
    parameter PW        = 2,
    parameter XCVR_IND  = 0,
    parameter SETUP_CYC = 2
) (
    // clock and reset
    input  wire          clk,
    input  wire          rstn,
    input  wire          clr,
    // control
    input  wire          run,
    input  wire          halt,
    // fifo head
    input  wire [PW*8-1:0] head,
    input  wire          empty,
    output reg           pop,
    // link
    input  wire          busy,
    output reg           strobe,
    output reg  [7:0]    byte_out,
    // head word progress
    output reg  [2:0]    taken
);
    localparam S_IDLE  = 2'h0;
    localparam S_SETUP = 2'h1;
    localparam S_STRB  = 2'h2;
    localparam S_REL   = 2'h3;

    reg [1:0] state;
    reg [3:0] cnt;
    wire [2:0] taken_inc = taken + 3'h1;
    wire       last      = (taken_inc == PW[2:0]);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state    <= S_IDLE;
            cnt      <= 4'h0;
            pop      <= 1'b0;
            strobe   <= 1'b0;
            byte_out <= 8'h00;
            taken    <= 3'h0;
        end else if (clr) begin
            state  <= S_IDLE;
            pop    <= 1'b0;
            strobe <= 1'b0;
            taken  <= 3'h0;
        end else begin
            pop <= 1'b0;
            // freeze on override: nothing advances while software holds the strobe
            if (!halt) begin
                case (state)
                    S_IDLE: begin
                        if (run && !empty && !pop) begin
                            byte_out <= head[taken*8 +: 8];
                            cnt      <= SETUP_CYC[3:0];
                            state    <= S_SETUP;
                            // byte leaves the fifo into the transceiver
                            if (XCVR_IND == 0) begin
                                taken <= last ? 3'h0 : taken_inc;
                                pop   <= last;
                            end
                        end
                    end
                    S_SETUP: begin
                        if (cnt <= 4'h1) begin
                            strobe <= 1'b1;
                            state  <= S_STRB;
                        end else begin
                            cnt <= cnt - 4'h1;
                        end
                    end
                    S_STRB: begin
                        if (busy) begin
                            strobe <= 1'b0;
                            state  <= S_REL;
                        end
                    end
                    S_REL: begin
                        if (!busy) begin
                            state <= S_IDLE;
                            // byte counted in the fifo until accepted
                            if (XCVR_IND != 0) begin
                                taken <= last ? 3'h0 : taken_inc;
                                pop   <= last;
                            end
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// >>> logic/ppr_regs.vh
`ifndef PPR_REGS_VH
`define PPR_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PPR_OFS_FIFO     4'h0
`define PPR_OFS_STATUS   4'h1
`define PPR_OFS_CTRL     4'h2
`define PPR_OFS_CFGA     4'h3
`define PPR_OFS_MODE     4'h4
`define PPR_OFS_IRQ_STAT 4'h5
`define PPR_OFS_IRQ_MASK 4'h6
`define PPR_OFS_COUNT    4'h7

// ----------------------------------------
// control register fields
// ----------------------------------------
`define PPR_CTRL_STROBE  0
`define PPR_CTRL_AUTOFD  1
`define PPR_CTRL_INIT    2
`define PPR_CTRL_DIR     5
`define PPR_CTRL_RESET   8'h04
`define PPR_PIN_IDLE     5'h1E

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define PPR_MODE_HI      7
`define PPR_MODE_LO      5
`define PPR_MODE_SPP     3'h0
`define PPR_MODE_PS2     3'h1
`define PPR_MODE_FIFO    3'h2
`define PPR_MODE_ECP     3'h3
`define PPR_MODE_RESET   3'h0
`define PPR_MODE_EMPTY   0
`define PPR_MODE_FULL    1

// ----------------------------------------
// configuration A fields
// ----------------------------------------
`define PPR_CFGA_LEVEL   7
`define PPR_CFGA_XCVR    2
`define PPR_IMP_W16      3'h0
`define PPR_IMP_W8       3'h1
`define PPR_IMP_W32      3'h2

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define PPR_IRQ_EMPTY    0
`define PPR_IRQ_PE_FALL  1
`define PPR_IRQ_PE_RISE  2
`define PPR_IRQ_SNAP     3
`define PPR_IRQ_BITS     4

// ----------------------------------------
// timing
// ----------------------------------------
`define PPR_CLK_MHZ      200
`define PPR_SETUP_NS     10
`define PPR_SETUP_CYC    ((`PPR_SETUP_NS * `PPR_CLK_MHZ + 999) / 1000)

`endif

// >>> logic/ppr_top.v
`timescale 1ns/1ps
`include "ppr_regs.vh"
module ppr_top #(
    parameter PW       = 2,
    parameter DEPTH    = 16,
    parameter AW       = 4,
    parameter XCVR_IND = 0
) (
    // clock and reset
    input  wire          clk,
    input  wire          rstn,
    // register port
    input  wire [3:0]    addr,
    input  wire [31:0]   wdata,
    input  wire          wr,
    input  wire          rd,
    output reg  [31:0]   rdata,
    // interrupt
    output reg           irq,
    // link outputs
    output reg  [7:0]    data_out,
    output reg           data_oe_n,
    output reg           strobe_n,
    output reg           autofd_n,
    output reg           init_n,
    // link inputs
    input  wire [7:0]    data_in,
    input  wire          busy,
    input  wire          pe,
    input  wire          ack_n,
    input  wire          fault_n,
    input  wire          select
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg  [4:0] sync1;
    reg  [4:0] sync2;
    reg  [7:0] din1;
    reg  [7:0] din2;
    reg        pe_d;
    wire       busy_s  = sync2[0];
    wire       pe_s    = sync2[1];
    wire       ack_s   = sync2[2];
    wire       fault_s = sync2[3];
    wire       sel_s   = sync2[4];

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // pins start at their idle levels so no false edge follows reset
            sync1 <= `PPR_PIN_IDLE;
            sync2 <= `PPR_PIN_IDLE;
            din1  <= 8'h00;
            din2  <= 8'h00;
            pe_d  <= 1'b1;
        end else begin
            sync1 <= {select, fault_n, ack_n, pe, busy};
            sync2 <= sync1;
            din1  <= data_in;
            din2  <= din1;
            pe_d  <= pe_s;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0] ctrl;
    reg  [2:0] mode;
    reg  [1:0] partial;
    reg  [`PPR_IRQ_BITS-1:0] irq_stat;
    reg  [`PPR_IRQ_BITS-1:0] irq_mask;
    reg        empty_d;
    wire [2:0] taken;
    wire       f_empty;
    wire       f_full;
    wire [AW:0] f_count;
    wire [PW*8-1:0] f_head;
    wire       f_pop;
    wire       hw_strobe;
    wire [7:0] hw_byte;

    function [2:0] imp_id;
        input integer w;
        begin
            if (w == 1) begin
                imp_id = `PPR_IMP_W8;
            end else if (w == 4) begin
                imp_id = `PPR_IMP_W32;
            end else begin
                imp_id = `PPR_IMP_W16;
            end
        end
    endfunction

    // bytes still owed in the head word
    function [1:0] enc_partial;
        input [2:0] t;
        input integer w;
        reg   [2:0] left;
        begin
            left = w[2:0] - t;
            enc_partial = (t == 3'h0) ? 2'h0 : left[1:0];
        end
    endfunction

    // modes 000 and 001 hold the fifo and engine in reset
    function clears_fifo;
        input [2:0] m;
        begin
            clears_fifo = (m == `PPR_MODE_SPP) || (m == `PPR_MODE_PS2);
        end
    endfunction

    wire       wr_fifo   = wr && (addr == `PPR_OFS_FIFO);
    wire       wr_mode   = wr && (addr == `PPR_OFS_MODE);
    wire [2:0] new_mode  = wdata[`PPR_MODE_HI:`PPR_MODE_LO];
    wire       to_reset  = clears_fifo(new_mode);
    // snapshot on leaving forward mode for a fifo-reset mode
    wire       snap      = wr_mode && (mode == `PPR_MODE_ECP) && to_reset;
    // fifo held in reset in modes 000 and 001
    wire       fifo_clr  = clears_fifo(mode);
    wire       rd_irq    = rd && (addr == `PPR_OFS_IRQ_STAT);
    wire [`PPR_IRQ_BITS-1:0] ev;

    assign ev[`PPR_IRQ_EMPTY]   = f_empty && !empty_d;
    assign ev[`PPR_IRQ_PE_FALL] = pe_d && !pe_s;
    assign ev[`PPR_IRQ_PE_RISE] = !pe_d && pe_s;
    assign ev[`PPR_IRQ_SNAP]    = snap;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl     <= `PPR_CTRL_RESET;
            mode     <= `PPR_MODE_RESET;
            partial  <= 2'h0;
            irq_stat <= {`PPR_IRQ_BITS{1'b0}};
            irq_mask <= {`PPR_IRQ_BITS{1'b0}};
            empty_d  <= 1'b1;
        end else begin
            empty_d <= f_empty;
            if (wr && (addr == `PPR_OFS_CTRL)) begin
                ctrl <= wdata[7:0];
            end
            if (wr_mode) begin
                mode <= new_mode;
            end
            // load partial state with the fifo reset
            if (snap) begin
                // single-byte words carry no partial state
                // held until the next exit from forward mode to a fifo-reset mode
                partial <= (PW == 1) ? 2'h0 : enc_partial(taken, PW);
            end
            if (wr && (addr == `PPR_OFS_IRQ_MASK)) begin
                irq_mask <= wdata[`PPR_IRQ_BITS-1:0];
            end
            // read clears, but a new event in the same cycle survives
            irq_stat <= (rd_irq ? {`PPR_IRQ_BITS{1'b0}} : irq_stat) | ev;
        end
    end

    // ----------------------------------------
    // fifo and forward engine
    // ----------------------------------------
    ppr_fifo #(
        .W     (PW*8),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_fifo (
        .clk      (clk),
        .rstn     (rstn),
        .clr      (fifo_clr),
        .wr_valid (wr_fifo),
        .wr_data  (wdata[PW*8-1:0]),
        .wr_ready (),
        .head     (f_head),
        .pop      (f_pop),
        .empty    (f_empty),
        .full     (f_full),
        .count    (f_count)
    );

    ppr_fwd #(
        .PW        (PW),
        .XCVR_IND  (XCVR_IND),
        .SETUP_CYC (`PPR_SETUP_CYC)
    ) u_fwd (
        .clk      (clk),
        .rstn     (rstn),
        .clr      (fifo_clr),
        .run      (mode == `PPR_MODE_ECP),
        .halt     (ctrl[`PPR_CTRL_STROBE]),
        .head     (f_head),
        .empty    (f_empty),
        .pop      (f_pop),
        .busy     (busy_s),
        .strobe   (hw_strobe),
        .byte_out (hw_byte),
        .taken    (taken)
    );

    // ----------------------------------------
    // link pins
    // ----------------------------------------
    // direction only takes effect outside the two standard modes
    wire tri_req = ctrl[`PPR_CTRL_DIR] && (mode != `PPR_MODE_SPP) && (mode != `PPR_MODE_FIFO);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_out  <= 8'h00;
            data_oe_n <= 1'b0;
            strobe_n  <= 1'b1;
            autofd_n  <= 1'b1;
            init_n    <= 1'b1;
            irq       <= 1'b0;
        end else begin
            data_out  <= hw_byte;
            // direction bit releases the data bus
            data_oe_n <= tri_req;
            // control bits override the handshake engine
            strobe_n  <= !(hw_strobe || ctrl[`PPR_CTRL_STROBE]);
            autofd_n  <= !ctrl[`PPR_CTRL_AUTOFD];
            // released by setting its bit, unlike strobe and autofd, to end recovery
            init_n    <= ctrl[`PPR_CTRL_INIT];
            irq       <= |(irq_stat & irq_mask);
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    reg [31:0] next_rdata;

    always @* begin
        next_rdata = 32'h0000_0000;
        case (addr)
            `PPR_OFS_STATUS: begin
                // busy visible for the drain check
                next_rdata[7:3] = {busy_s, ack_s, pe_s, sel_s, fault_s};
            end
            `PPR_OFS_CTRL: begin
                next_rdata[5:0] = ctrl[5:0];
            end
            `PPR_OFS_CFGA: begin
                next_rdata[`PPR_CFGA_LEVEL] = 1'b1;
                next_rdata[6:4] = imp_id(PW);
                next_rdata[`PPR_CFGA_XCVR] = (XCVR_IND != 0);
                next_rdata[1:0] = partial;
            end
            `PPR_OFS_MODE: begin
                next_rdata[`PPR_MODE_HI:`PPR_MODE_LO] = mode;
                // full flag for the fill count
                next_rdata[`PPR_MODE_FULL]  = f_full;
                next_rdata[`PPR_MODE_EMPTY] = f_empty;
            end
            `PPR_OFS_IRQ_STAT: begin
                next_rdata[`PPR_IRQ_BITS-1:0] = irq_stat;
            end
            `PPR_OFS_IRQ_MASK: begin
                next_rdata[`PPR_IRQ_BITS-1:0] = irq_mask;
            end
            `PPR_OFS_COUNT: begin
                next_rdata[AW:0] = f_count;
                next_rdata[15:8] = din2;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data stands one cycle after the strobe and is zero otherwise
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? next_rdata : 32'h0000_0000;
        end
    end
endmodule

// >>> verification/ppr_peer.sv
`timescale 1ns/1ps
module ppr_peer (
    // clock and reset
    input  wire       clk,
    input  wire       rstn,
    // scenario control
    input  wire       stall,
    input  wire       slow,
    // from host
    input  wire [7:0] data_out,
    input  wire       strobe_n,
    input  wire       init_n,
    // to host
    output reg  [7:0] data_in,
    output reg        busy,
    output reg        pe,
    output wire       ack_n,
    output wire       fault_n,
    output wire       select
);
    reg  [7:0] rx [0:15];
    reg  [4:0] rx_cnt;
    reg        strobe_q;
    reg  [2:0] wait_cnt;
    wire       want = !strobe_n && !stall;
    assign ack_n   = ~busy;
    assign fault_n = 1'b1;
    assign select  = 1'b1;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy     <= 1'b0;
            pe       <= 1'b1;
            rx_cnt   <= 5'h00;
            strobe_q <= 1'b1;
            wait_cnt <= 3'h0;
            data_in  <= 8'h00;
        end else begin
            strobe_q <= strobe_n;
            // echoes the inverse of the host byte so a stale bus value is never mistaken for data
            data_in  <= ~data_out;
            if (strobe_q && !strobe_n && rx_cnt < 5'h10) begin
                rx[rx_cnt[3:0]] <= data_out;
                rx_cnt          <= rx_cnt + 5'h01;
            end
            if (want == busy) wait_cnt <= 3'h0;
            else if (wait_cnt >= (slow ? 3'h6 : 3'h1)) begin
                busy     <= want;
                wait_cnt <= 3'h0;
            end else wait_cnt <= wait_cnt + 3'h1;
            pe <= init_n;
        end
    end
endmodule

// >>> verification/ppr_top_asserts.sv
`timescale 1ns/1ps
`include "ppr_regs.vh"
module ppr_top_asserts #(
    parameter PW       = 2,
    parameter XCVR_IND = 0
) (
    // clock and reset
    input wire        clk,
    input wire        rstn,
    // register port
    input wire [3:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata,
    input wire        irq,
    // link
    input wire [7:0]  data_out,
    input wire        data_oe_n,
    input wire        strobe_n,
    input wire        autofd_n,
    input wire        init_n
);
    localparam [2:0] IMPID = (PW == 1) ? `PPR_IMP_W8 : (PW == 4) ? `PPR_IMP_W32 : `PPR_IMP_W16;
    reg [5:0] ctrl_q;
    reg [2:0] mode_q;
    reg [3:0] mask_q;
    reg [1:0] hold_cnt;
    wire      ctrl_wr = wr && addr == `PPR_OFS_CTRL;
    // ----------------------------------------
    // shadow of the written registers
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q   <= 6'h04;
            mode_q   <= 3'h0;
            mask_q   <= 4'h0;
            hold_cnt <= 2'h0;
        end else begin
            if (ctrl_wr) ctrl_q <= wdata[5:0];
            if (wr && addr == `PPR_OFS_MODE) mode_q <= wdata[7:5];
            if (wr && addr == `PPR_OFS_IRQ_MASK) mask_q <= wdata[3:0];
            // a few cycles of margin: the freeze may land one edge after the write
            hold_cnt <= (ctrl_q[0] && mode_q == 3'h3) ? ((hold_cnt == 2'h3) ? 2'h3 : hold_cnt + 2'h1) : 2'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not zero");
    a_cfga_fields: assert property (rd && addr == `PPR_OFS_CFGA |=> rdata[7] && rdata[6:4] == IMPID
        && rdata[2] == XCVR_IND[0]) else $error("config A fixed fields wrong");
    a_strobe_force: assert property (ctrl_wr && wdata[0] |-> ##[1:2] !strobe_n) else $error("strobe not forced");
    a_autofd_force: assert property (ctrl_wr && wdata[1] |-> ##[1:2] !autofd_n) else $error("autofd not forced");
    a_autofd_idle: assert property (!ctrl_q[1] && !$past(ctrl_q[1]) |-> autofd_n) else $error("autofd driven");
    a_init_low: assert property (ctrl_wr && !wdata[2] |-> ##[1:2] !init_n) else $error("init not low");
    a_dir_tristate: assert property (ctrl_wr && wdata[5] && mode_q == 3'h1 |-> ##[1:2] data_oe_n)
        else $error("drivers not released");
    a_halt_freeze: assert property (hold_cnt == 2'h3 |-> !strobe_n && $stable(data_out))
        else $error("transfer moved while halted");
    a_irq_masked: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq) else $error("irq while masked");
    c_halt: cover property (hold_cnt == 2'h3);
    c_snap: cover property (wr && addr == `PPR_OFS_MODE && wdata[7:5] == 3'h1 && mode_q == 3'h3);
    c_irq: cover property ($rose(irq));
endmodule
bind ppr_top ppr_top_asserts #(.PW(PW), .XCVR_IND(XCVR_IND)) chk_u (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .data_out(data_out), .data_oe_n(data_oe_n),
    .strobe_n(strobe_n), .autofd_n(autofd_n), .init_n(init_n));

// >>> verification/test_parallel_port_host_recovery.sv
`timescale 1ns/1ps
`include "ppr_regs.vh"
module test_parallel_port_host_recovery;
    localparam DEPTH = 16;
    reg         clk, rstn, wr, rd, stall, slow;
    reg  [3:0]  addr;
    reg  [31:0] wdata, d;
    wire [31:0] rdata;
    wire [7:0]  data_out, data_in;
    wire        irq, data_oe_n, strobe_n, autofd_n, init_n, busy, pe, ack_n, fault_n, select;
    integer     errors, cmp_count, n;
    wire [3:0]  pins = {irq, data_oe_n, strobe_n, autofd_n};
    localparam  P_AUTOFD = 0, P_STROBE = 1, P_OE = 2, P_IRQ = 3;
    ppr_top #(.PW(2), .DEPTH(DEPTH), .AW(4), .XCVR_IND(0)) dut_u (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .data_out(data_out), .data_oe_n(data_oe_n),
        .strobe_n(strobe_n), .autofd_n(autofd_n), .init_n(init_n), .data_in(data_in), .busy(busy), .pe(pe),
        .ack_n(ack_n), .fault_n(fault_n), .select(select));
    ppr_peer peer_u (.clk(clk), .rstn(rstn), .stall(stall), .slow(slow), .data_out(data_out),
        .strobe_n(strobe_n), .init_n(init_n), .data_in(data_in), .busy(busy), .pe(pe), .ack_n(ack_n),
        .fault_n(fault_n), .select(select));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task check(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task reg_wr(input [3:0] a, input [31:0] v);
        begin
            @(posedge clk);
            addr  <= a;
            wdata <= v;
            wr    <= 1'b1;
            @(posedge clk);
            wr    <= 1'b0;
        end
    endtask
    task reg_rd(input [3:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd   <= 1'b1;
            @(posedge clk);
            rd   <= 1'b0;
            #1 d = rdata;
        end
    endtask
    task rd_chk(input [3:0] a, input [31:0] m, input [31:0] exp);
        begin
            reg_rd(a);
            check(d & m, exp);
        end
    endtask
    task pin_chk(input integer p, input exp);
        begin
            repeat (2) @(posedge clk);
            #1 check({31'h0, pins[p]}, {31'h0, exp});
        end
    endtask
    task wait_bit(input [3:0] a, input integer b, input v);
        integer k;
        begin
            k = 0;
            reg_rd(a);
            while (d[b] !== v && k < 60) begin
                reg_rd(a);
                k = k + 1;
            end
            check({31'h0, d[b]}, {31'h0, v});
        end
    endtask
    task wait_rx(input integer cnt);
        integer k;
        begin
            for (k = 0; k < 400 && peer_u.rx_cnt != cnt; k = k + 1) @(posedge clk);
            check({27'h0, peer_u.rx_cnt}, cnt);
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d errors %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #60000;
        errors = errors + 1;
        summarize;
    end
    initial begin
        errors = 0; cmp_count = 0; addr = 4'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
        stall = 1'b0; slow = 1'b1; rstn = 1'b0;
        repeat (3) @(posedge clk);
        check({28'h0, strobe_n, autofd_n, init_n, irq}, 32'hE);
        rstn <= 1'b1;
        rd_chk(`PPR_OFS_CTRL, 32'h3F, 32'h04);
        rd_chk(`PPR_OFS_MODE, 32'hE3, 32'h01);
        rd_chk(`PPR_OFS_CFGA, 32'hFF, 32'h80);
        rd_chk(`PPR_OFS_STATUS, 32'hF8, 32'h78);
        rd_chk(`PPR_OFS_IRQ_STAT, 32'hF, 32'h0);
        reg_wr(4'h8, 32'hFF);
        rd_chk(4'h8, 32'hFFFFFFFF, 32'h0);
        reg_wr(`PPR_OFS_CFGA, 32'h7F);
        rd_chk(`PPR_OFS_CFGA, 32'hFF, 32'h80);
        reg_wr(`PPR_OFS_CTRL, 32'h06);
        pin_chk(P_AUTOFD, 1'b0);
        reg_wr(`PPR_OFS_CTRL, 32'h04);
        // forward transfer, slow peripheral
        reg_wr(`PPR_OFS_IRQ_MASK, 32'h09);
        reg_wr(`PPR_OFS_MODE, 32'h60);
        reg_wr(`PPR_OFS_FIFO, 32'h2211);
        reg_wr(`PPR_OFS_FIFO, 32'h4433);
        wait_rx(4);
        wait_bit(`PPR_OFS_MODE, `PPR_MODE_EMPTY, 1'b1);
        wait_bit(`PPR_OFS_STATUS, 7, 1'b1);
        wait_bit(`PPR_OFS_STATUS, 7, 1'b0);
        for (n = 0; n < 4; n = n + 1) check({24'h0, peer_u.rx[n]}, 32'h11 * (n + 1));
        check({31'h0, irq}, 32'h1);
        rd_chk(`PPR_OFS_IRQ_STAT, 32'h1, 32'h1);
        pin_chk(P_IRQ, 1'b0);
        // stalled at the strobe: one byte of the head word loaded
        stall = 1'b1;
        slow  = 1'b0;
        reg_wr(`PPR_OFS_FIFO, 32'h6655);
        reg_wr(`PPR_OFS_FIFO, 32'h8877);
        reg_wr(`PPR_OFS_FIFO, 32'hAA99);
        wait_rx(5);
        check({24'h0, peer_u.rx[4]}, 32'h55);
        reg_wr(`PPR_OFS_CTRL, 32'h05);
        stall = 1'b0;
        repeat (40) @(posedge clk);
        wait_rx(5);
        pin_chk(P_STROBE, 1'b0);
        n = 0;
        reg_rd(`PPR_OFS_MODE);
        while (d[`PPR_MODE_FULL] !== 1'b1 && n < 20) begin
            reg_wr(`PPR_OFS_FIFO, n);
            n = n + 1;
            reg_rd(`PPR_OFS_MODE);
        end
        check(n, DEPTH - 3);
        rd_chk(`PPR_OFS_COUNT, 32'h1F, DEPTH);
        reg_wr(`PPR_OFS_MODE, 32'h20);
        rd_chk(`PPR_OFS_CFGA, 32'h87, 32'h81);
        rd_chk(`PPR_OFS_MODE, 32'hE3, 32'h21);
        // recovery handshake
        reg_wr(`PPR_OFS_CTRL, 32'h25);
        pin_chk(P_OE, 1'b1);
        reg_wr(`PPR_OFS_CTRL, 32'h21);
        wait_bit(`PPR_OFS_STATUS, 5, 1'b0);
        reg_wr(`PPR_OFS_CTRL, 32'h20);
        pin_chk(P_STROBE, 1'b1);
        reg_wr(`PPR_OFS_CTRL, 32'h24);
        wait_bit(`PPR_OFS_STATUS, 5, 1'b1);
        reg_wr(`PPR_OFS_IRQ_MASK, 32'h00);
        pin_chk(P_IRQ, 1'b0);
        reg_wr(`PPR_OFS_IRQ_MASK, 32'h08);
        pin_chk(P_IRQ, 1'b1);
        rd_chk(`PPR_OFS_IRQ_STAT, 32'hE, 32'hE);
        pin_chk(P_IRQ, 1'b0);
        reg_wr(`PPR_OFS_MODE, 32'h00);
        rd_chk(`PPR_OFS_CFGA, 32'h87, 32'h81);
        check((DEPTH - n - (d[1:0] != 2'h0)) * 2 + d[1:0] + !d[2], 32'h6);
        summarize;
    end
endmodule
